/* File: etp_map.svh */
`ifndef ETP_MAP_SVH
`define ETP_MAP_SVH

// Register byte offsets on the APB window
`define ETP_PRESCALE_OFF    8'h00
`define ETP_CONTROL_OFF     8'h04
`define ETP_FLAGS_OFF       8'h08
`define ETP_CLEAR_OFF       8'h0c
`define ETP_FORCE_OFF       8'h10

// Prescale register fields
`define ETP_CONVA_CNT_MSB   11
`define ETP_CONVA_CNT_LSB   10
`define ETP_CONVA_PRD_MSB   9
`define ETP_CONVA_PRD_LSB   8
`define ETP_IRQ_CNT_MSB     3
`define ETP_IRQ_CNT_LSB     2
`define ETP_IRQ_PRD_MSB     1
`define ETP_IRQ_PRD_LSB     0

// Control, flag and clear bit positions; the force register acts on the interrupt bit only
`define ETP_CONVA_BIT       0
`define ETP_IRQ_BIT         1

// Reset values
`define ETP_PRD_RESET       2'h0
`define ETP_CNT_RESET       2'h0
`define ETP_EN_RESET        1'h0
`define ETP_FLAG_RESET      1'h0

// Answer of the slave, in cycles after the setup cycle
`define ETP_APB_WAIT        1

`endif

/* File: etp_pkg.sv */
package etp_pkg;

    typedef logic [1:0] etp_period_t;

    typedef enum logic {
        ETP_BUS_IDLE,
        ETP_BUS_ANSWER
    } etp_bus_state_t;

endpackage : etp_pkg

/* File: etp_event_counter.sv */
`timescale 1ns/10ps
`include "etp_map.svh"

module etp_event_counter #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         eventIn,
    input  wire logic [W-1:0] periodSel,
    input  wire logic         fireAllow,
    input  wire logic         forceIn,
    output logic [W-1:0]      count,
    output logic              fire
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic [W-1:0] stepped;
    logic         reach;

    always_comb begin
        stepped    = count_reg + {{(W-1){1'b0}}, eventIn};
        // A period written equal to the count fires without a new event
        reach      = (count_reg == periodSel) || (stepped == periodSel);
        count_next = count_reg;
        fire       = 1'b0;
        if (periodSel != '0) begin
            if (fireAllow && (reach || forceIn)) begin
                fire       = 1'b1;
                count_next = '0;
            end else if (!fireAllow && count_reg == periodSel) begin
                // saturate while blocked
                // Blocked output: saturate so a pending firing is not lost
                count_next = count_reg;
            end else begin
                count_next = stepped;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule : etp_event_counter

/* File: etp_event_trigger_prescaler.sv */
`timescale 1ns/10ps
`include "etp_map.svh"

module etp_event_trigger_prescaler #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              convAEventIn,
    input  wire logic              irqEventIn,
    output logic                   convATriggerPulse,
    output logic                   irqPulse
);

    etp_pkg::etp_period_t convAPeriodSel_reg;
    etp_pkg::etp_period_t convAPeriodSel_next;
    etp_pkg::etp_period_t irqPeriodSel_reg;
    etp_pkg::etp_period_t irqPeriodSel_next;
    logic                 convATriggerEnable_reg;
    logic                 convATriggerEnable_next;
    logic                 irqEnable_reg;
    logic                 irqEnable_next;
    logic                 convAStatusFlag_reg;
    logic                 convAStatusFlag_next;
    logic                 irqFlag_reg;
    logic                 irqFlag_next;
    logic                 convAPulse_reg;
    logic                 convAPulse_next;
    logic                 irqPulse_reg;
    logic                 irqPulse_next;

    etp_pkg::etp_bus_state_t busState_reg;
    etp_pkg::etp_bus_state_t busState_next;
    logic [31:0]             prdata_reg;
    logic [31:0]             prdata_next;
    logic                    pready_reg;
    logic                    pready_next;
    logic                    pslverr_reg;
    logic                    pslverr_next;

    etp_pkg::etp_period_t convAEventCount;
    etp_pkg::etp_period_t irqEventCount;
    logic                 convAFire;
    logic                 irqFire;
    logic                 irqAllow;
    logic                 writeDone;
    logic                 mapped;
    logic                 irqForce;

    assign writeDone = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign irqForce  = writeDone && paddr == `ETP_FORCE_OFF && pwdata[`ETP_IRQ_BIT];
    // gate on flag
    // A pending interrupt flag holds back the next interrupt
    assign irqAllow  = irqEnable_reg && !irqFlag_reg;

    etp_event_counter #(
        .W(2)
    ) u_conv_a_counter (
        .clk       (clk),
        .rst       (rst),
        .eventIn   (convAEventIn),
        .periodSel (convAPeriodSel_reg),
        .fireAllow (convATriggerEnable_reg),
        .forceIn   (1'b0),
        .count     (convAEventCount),
        .fire      (convAFire)
    );

    etp_event_counter #(
        .W(2)
    ) u_irq_counter (
        .clk       (clk),
        .rst       (rst),
        .eventIn   (irqEventIn),
        .periodSel (irqPeriodSel_reg),
        .fireAllow (irqAllow),
        .forceIn   (irqForce),
        .count     (irqEventCount),
        .fire      (irqFire)
    );

    always_comb begin
        mapped = (paddr == `ETP_PRESCALE_OFF) || (paddr == `ETP_CONTROL_OFF)
              || (paddr == `ETP_FLAGS_OFF) || (paddr == `ETP_CLEAR_OFF)
              || (paddr == `ETP_FORCE_OFF);
        busState_next = busState_reg;
        pready_next   = 1'b0;
        pslverr_next  = 1'b0;
        prdata_next   = prdata_reg;
        unique case (busState_reg)
            etp_pkg::ETP_BUS_IDLE: begin
                if (psel && !penable) begin
                    busState_next = etp_pkg::ETP_BUS_ANSWER;
                    pready_next   = 1'b1;
                    pslverr_next  = !mapped;
                    prdata_next   = 32'h0000_0000;
                    if (!pwrite) begin
                        if (paddr == `ETP_PRESCALE_OFF) begin
                            prdata_next[`ETP_CONVA_CNT_MSB:`ETP_CONVA_CNT_LSB] = convAEventCount;
                            prdata_next[`ETP_CONVA_PRD_MSB:`ETP_CONVA_PRD_LSB] = convAPeriodSel_reg;
                            prdata_next[`ETP_IRQ_CNT_MSB:`ETP_IRQ_CNT_LSB]     = irqEventCount;
                            prdata_next[`ETP_IRQ_PRD_MSB:`ETP_IRQ_PRD_LSB]     = irqPeriodSel_reg;
                        end else if (paddr == `ETP_CONTROL_OFF) begin
                            prdata_next[`ETP_CONVA_BIT] = convATriggerEnable_reg;
                            prdata_next[`ETP_IRQ_BIT]   = irqEnable_reg;
                        end else if (paddr == `ETP_FLAGS_OFF) begin
                            prdata_next[`ETP_CONVA_BIT] = convAStatusFlag_reg;
                            prdata_next[`ETP_IRQ_BIT]   = irqFlag_reg;
                        end
                    end
                end
            end
            etp_pkg::ETP_BUS_ANSWER: begin
                busState_next = etp_pkg::ETP_BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        convAPeriodSel_next     = convAPeriodSel_reg;
        irqPeriodSel_next       = irqPeriodSel_reg;
        convATriggerEnable_next = convATriggerEnable_reg;
        irqEnable_next          = irqEnable_reg;
        convAStatusFlag_next    = convAStatusFlag_reg;
        irqFlag_next            = irqFlag_reg;
        if (writeDone) begin
            // period selects written, counts read only
            if (paddr == `ETP_PRESCALE_OFF) begin
                convAPeriodSel_next = pwdata[`ETP_CONVA_PRD_MSB:`ETP_CONVA_PRD_LSB];
                irqPeriodSel_next   = pwdata[`ETP_IRQ_PRD_MSB:`ETP_IRQ_PRD_LSB];
            end
            if (paddr == `ETP_CONTROL_OFF) begin
                convATriggerEnable_next = pwdata[`ETP_CONVA_BIT];
                irqEnable_next          = pwdata[`ETP_IRQ_BIT];
            end
            if (paddr == `ETP_CLEAR_OFF) begin
                if (pwdata[`ETP_CONVA_BIT]) begin
                    convAStatusFlag_next = 1'b0;
                end
                if (pwdata[`ETP_IRQ_BIT]) begin
                    irqFlag_next = 1'b0;
                end
            end
        end
        // Set wins over a clear in the same cycle
        if (convAFire) begin
            convAStatusFlag_next = 1'b1;
        end
        if (irqFire) begin
            irqFlag_next = 1'b1;
        end
        convAPulse_next = convAFire;
        irqPulse_next   = irqFire;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busState_reg           <= etp_pkg::ETP_BUS_IDLE;
            prdata_reg             <= 32'h0000_0000;
            pready_reg             <= 1'b0;
            pslverr_reg            <= 1'b0;
            convAPeriodSel_reg     <= `ETP_PRD_RESET;
            irqPeriodSel_reg       <= `ETP_PRD_RESET;
            convATriggerEnable_reg <= `ETP_EN_RESET;
            irqEnable_reg          <= `ETP_EN_RESET;
            convAStatusFlag_reg    <= `ETP_FLAG_RESET;
            irqFlag_reg            <= `ETP_FLAG_RESET;
            convAPulse_reg         <= 1'b0;
            irqPulse_reg           <= 1'b0;
        end else begin
            busState_reg           <= busState_next;
            prdata_reg             <= prdata_next;
            pready_reg             <= pready_next;
            pslverr_reg            <= pslverr_next;
            convAPeriodSel_reg     <= convAPeriodSel_next;
            irqPeriodSel_reg       <= irqPeriodSel_next;
            convATriggerEnable_reg <= convATriggerEnable_next;
            irqEnable_reg          <= irqEnable_next;
            convAStatusFlag_reg    <= convAStatusFlag_next;
            irqFlag_reg            <= irqFlag_next;
            convAPulse_reg         <= convAPulse_next;
            irqPulse_reg           <= irqPulse_next;
        end
    end

    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign convATriggerPulse = convAPulse_reg;
    assign irqPulse          = irqPulse_reg;

    sequence convAStepSeq;
        convAEventIn && convAPeriodSel_reg != 2'h0 && !convAFire
            && !(!convATriggerEnable_reg && convAEventCount == convAPeriodSel_reg);
    endsequence

    sequence convAHitSeq;
        convATriggerEnable_reg && convAEventIn && convAPeriodSel_reg != 2'h0
            && 2'(convAEventCount + 2'h1) == convAPeriodSel_reg;
    endsequence

    sequence irqBlockedFullSeq;
        (!irqEnable_reg || irqFlag_reg) && irqPeriodSel_reg != 2'h0
            && irqEventCount == irqPeriodSel_reg;
    endsequence

    conv_count_step_a: assert property (@(posedge clk) disable iff (rst)
        convAStepSeq |=> convAEventCount == 2'($past(convAEventCount) + 2'h1))
        else $error("conversion-A count did not step on an event");

    conv_period_hit_a: assert property (@(posedge clk) disable iff (rst)
        convAHitSeq |=> convATriggerPulse)
        else $error("conversion-A trigger missing at period");

    conv_off_a: assert property (@(posedge clk) disable iff (rst)
        convAPeriodSel_reg == 2'h0 |=> !convATriggerPulse)
        else $error("conversion-A trigger with period zero");

    conv_enable_gate_a: assert property (@(posedge clk) disable iff (rst)
        !convATriggerEnable_reg |=> !convATriggerPulse)
        else $error("conversion-A trigger while disabled");

    conv_flag_pass_a: assert property (@(posedge clk) disable iff (rst)
        convAStatusFlag_reg ##0 convAHitSeq |=> convATriggerPulse && convAStatusFlag_reg)
        else $error("conversion-A trigger held back by status flag");

    conv_count_clear_a: assert property (@(posedge clk) disable iff (rst)
        convATriggerPulse |-> convAEventCount == 2'h0)
        else $error("conversion-A count not cleared after trigger");

    irq_count_clear_a: assert property (@(posedge clk) disable iff (rst)
        irqPulse |-> irqEventCount == 2'h0 && irqFlag_reg)
        else $error("interrupt count not cleared on interrupt");

    irq_saturate_a: assert property (@(posedge clk) disable iff (rst)
        irqBlockedFullSeq |=> irqEventCount == $past(irqEventCount))
        else $error("blocked interrupt count moved past period");

    irq_fire_a: assert property (@(posedge clk) disable iff (rst)
        irqAllow && irqPeriodSel_reg != 2'h0 && irqEventCount == irqPeriodSel_reg
            |=> irqPulse)
        else $error("interrupt missing at period");

    irq_flag_block_a: assert property (@(posedge clk) disable iff (rst)
        irqFlag_reg |=> !irqPulse)
        else $error("interrupt while flag pending");

    irq_off_a: assert property (@(posedge clk) disable iff (rst)
        irqPeriodSel_reg == 2'h0 |=> !irqPulse && irqEventCount == $past(irqEventCount))
        else $error("interrupt counter active with period zero");

    irq_one_cycle_a: assert property (@(posedge clk) disable iff (rst)
        irqPulse |=> !irqPulse)
        else $error("interrupt pulse longer than one cycle");

    conv_count_hold_a: assert property (@(posedge clk) disable iff (rst)
        !convATriggerEnable_reg && convAPeriodSel_reg != 2'h0
            && convAEventCount == convAPeriodSel_reg
            |=> convAEventCount == $past(convAEventCount))
        else $error("disabled conversion-A count moved past period");

    irq_count_step_a: assert property (@(posedge clk) disable iff (rst)
        irqEventIn && irqPeriodSel_reg != 2'h0 && !irqFire
            && !(!irqAllow && irqEventCount == irqPeriodSel_reg)
            |=> irqEventCount == 2'($past(irqEventCount) + 2'h1))
        else $error("interrupt count did not step on an event");

    irq_force_fire_a: assert property (@(posedge clk) disable iff (rst)
        irqForce && irqAllow && irqPeriodSel_reg != 2'h0 |=> irqPulse)
        else $error("forced interrupt missing");

    conv_period_store_a: assert property (@(posedge clk) disable iff (rst)
        writeDone && paddr == `ETP_PRESCALE_OFF
            |=> convAPeriodSel_reg == $past(pwdata[`ETP_CONVA_PRD_MSB:`ETP_CONVA_PRD_LSB]))
        else $error("conversion-A period not stored");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        psel && penable && pready && !pwrite && paddr == `ETP_PRESCALE_OFF
            |-> prdata[7:4] == 4'h0 && prdata[31:12] == 20'h0_0000)
        else $error("reserved prescale bits read non-zero");

endmodule : etp_event_trigger_prescaler

/* File: etp_far_side_model.sv */
`timescale 1ns/10ps

// Converter start input and interrupt controller; they only watch the pulses
module etp_far_side_model (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  convStart,
    input  wire logic  irqLine,
    output logic [7:0] convSeen,
    output logic [7:0] irqSeen,
    output logic       wideSeen
);
    logic convPrev;
    logic irqPrev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convPrev <= 1'b0;
            irqPrev  <= 1'b0;
            convSeen <= 8'h00;
            irqSeen  <= 8'h00;
            wideSeen <= 1'b0;
        end else begin
            convPrev <= convStart;
            irqPrev  <= irqLine;
            if (convStart && !convPrev) convSeen <= convSeen + 8'h01;
            if (irqLine && !irqPrev) irqSeen <= irqSeen + 8'h01;
            // A pulse held two cycles would start two conversions
            if ((convStart && convPrev) || (irqLine && irqPrev)) wideSeen <= 1'b1;
        end
    end
endmodule : etp_far_side_model

/* File: testbench.sv */
`timescale 1ns/10ps
`include "etp_map.svh"

module testbench;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        convAEventIn;
    logic        irqEventIn;
    logic        convATriggerPulse;
    logic        irqPulse;
    logic [7:0]  convSeen;
    logic [7:0]  irqSeen;
    logic        wideSeen;
    logic [7:0]  expA;
    logic [7:0]  expI;
    logic [31:0] q;
    logic        e;
    int          fails;
    int          comparisons;

    etp_event_trigger_prescaler u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convAEventIn(convAEventIn), .irqEventIn(irqEventIn),
        .convATriggerPulse(convATriggerPulse), .irqPulse(irqPulse)
    );

    etp_far_side_model u_far (
        .clk(clk), .rst(rst), .convStart(convATriggerPulse), .irqLine(irqPulse),
        .convSeen(convSeen), .irqSeen(irqSeen), .wideSeen(wideSeen)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fails++;
            stop_test();
        end else begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd

    task ev(input logic a, input logic i, input int n);
        repeat (n) begin
            @(posedge clk);
            convAEventIn <= a;
            irqEventIn <= i;
            @(posedge clk);
            convAEventIn <= 1'b0;
            irqEventIn <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : ev

    task pulses;
        check({convSeen, irqSeen}, {expA, expI});
    endtask : pulses

    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        convAEventIn = 1'b0;
        irqEventIn = 1'b0;
        fails = 0;
        comparisons = 0;
        expA = 8'h00;
        expI = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`ETP_PRESCALE_OFF, 32'h0);
        rd(`ETP_FLAGS_OFF, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(`ETP_PRESCALE_OFF, 32'hffffffff);
        rd(`ETP_PRESCALE_OFF, 32'h00000303);
        $display("test reset and map done");
        wr(`ETP_PRESCALE_OFF, 32'h0);
        wr(`ETP_CONTROL_OFF, 32'h1);
        ev(1'b1, 1'b0, 3);
        pulses();
        for (int p = 1; p < 4; p++) begin
            wr(`ETP_PRESCALE_OFF, 32'(p) << 8);
            ev(1'b1, 1'b0, p - 1);
            rd(`ETP_PRESCALE_OFF, (32'(p - 1) << 10) | (32'(p) << 8));
            pulses();
            ev(1'b1, 1'b0, 1);
            expA = expA + 8'h01;
            pulses();
            rd(`ETP_PRESCALE_OFF, 32'(p) << 8);
        end
        rd(`ETP_FLAGS_OFF, 32'h1);
        wr(`ETP_CONTROL_OFF, 32'h0);
        wr(`ETP_PRESCALE_OFF, 32'h200);
        ev(1'b1, 1'b0, 3);
        pulses();
        rd(`ETP_PRESCALE_OFF, 32'ha00);
        wr(`ETP_CONTROL_OFF, 32'h1);
        repeat (3) @(posedge clk);
        expA = expA + 8'h01;
        pulses();
        $display("test conversion trigger done");
        wr(`ETP_PRESCALE_OFF, 32'h0);
        wr(`ETP_CONTROL_OFF, 32'h2);
        for (int p = 1; p < 4; p++) begin
            wr(`ETP_CLEAR_OFF, 32'h3);
            wr(`ETP_PRESCALE_OFF, 32'(p));
            ev(1'b0, 1'b1, p - 1);
            rd(`ETP_PRESCALE_OFF, (32'(p - 1) << 2) | 32'(p));
            ev(1'b0, 1'b1, 1);
            expI = expI + 8'h01;
            pulses();
            rd(`ETP_PRESCALE_OFF, 32'(p));
        end
        wr(`ETP_PRESCALE_OFF, 32'h2);
        ev(1'b0, 1'b1, 3);
        pulses();
        rd(`ETP_PRESCALE_OFF, 32'ha);
        wr(`ETP_CLEAR_OFF, 32'h2);
        repeat (3) @(posedge clk);
        expI = expI + 8'h01;
        pulses();
        rd(`ETP_FLAGS_OFF, 32'h2);
        $display("test interrupt count done");
        wr(`ETP_CLEAR_OFF, 32'h2);
        wr(`ETP_PRESCALE_OFF, 32'h0);
        wr(`ETP_FORCE_OFF, 32'h2);
        ev(1'b0, 1'b1, 2);
        pulses();
        rd(`ETP_PRESCALE_OFF, 32'h0);
        wr(`ETP_PRESCALE_OFF, 32'h1);
        wr(`ETP_FORCE_OFF, 32'h2);
        repeat (3) @(posedge clk);
        expI = expI + 8'h01;
        pulses();
        wr(`ETP_CLEAR_OFF, 32'h2);
        wr(`ETP_CONTROL_OFF, 32'h0);
        ev(1'b0, 1'b1, 3);
        rd(`ETP_PRESCALE_OFF, 32'h5);
        pulses();
        wr(`ETP_CONTROL_OFF, 32'h2);
        repeat (3) @(posedge clk);
        expI = expI + 8'h01;
        pulses();
        check({31'h0, wideSeen}, 32'h0);
        $display("test force and enable done");
        stop_test();
    end
endmodule : testbench
